// ---- core/sdp_pkg.sv ----
package sdp_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 18;
	localparam logic [3:0] ADDR_POWER = 4'h2;
	localparam logic [3:0] ADDR_RF1_N = 4'h3;
	localparam logic [3:0] ADDR_RF2_N = 4'h4;
	localparam logic [3:0] ADDR_IF_N = 4'h5;
	localparam logic [3:0] ADDR_RF1_R = 4'h6;
	localparam logic [3:0] ADDR_RF2_R = 4'h7;
	localparam logic [3:0] ADDR_RSV_LO = 4'h9;
	localparam int BIT_IF_ON = 1;
	localparam int BIT_RF_ON = 0;
	localparam int RF1_N_W = 18;
	localparam int RF2_N_W = 17;
	localparam int IF_N_W = 16;
	localparam int REF_W = 13;
	localparam logic [17:0] RF1_N_MIN = 18'h0_03e0;
	localparam logic [16:0] RF2_N_MIN = 17'h0_00f0;
	localparam logic [15:0] IF_N_MIN = 16'h0038;
	localparam logic [12:0] RF2_R_MAX = 13'h1ffd;
	localparam logic [12:0] RF2_R_MIN_G0 = 13'h0007;
	localparam logic [12:0] RF2_R_MIN_G1 = 13'h0008;
	localparam logic [12:0] RF2_R_MIN_G2 = 13'h000a;
	localparam logic [12:0] RF2_R_MIN_G3 = 13'h000e;
	// host register offsets
	localparam logic [3:0] HREG_DATA = 4'h0;
	localparam logic [3:0] HREG_CMD = 4'h1;
	localparam logic [3:0] HREG_STATUS = 4'h2;
	typedef enum logic [1:0] {
		SDP_IDLE = 2'b00,
		SDP_SEND = 2'b01,
		SDP_REJECT = 2'b10
	} sdp_state_e;
endpackage

// ---- core/sdp_link_if.sv ----
interface sdp_link_if;
	import sdp_pkg::*;
	logic wr_valid;
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;
	modport device (input wr_valid, input wr_addr, input wr_data);
	modport host (output wr_valid, output wr_addr, output wr_data);
endinterface

// ---- core/sdp_rf2_ref_check.sv ----
// range check for an rf2 reference count against the gain code
module sdp_rf2_ref_check
	import sdp_pkg::*;
(
	input wire logic [REF_W-1:0] value,
	input wire logic [1:0] gain_code,
	output logic ok
);
	logic [REF_W-1:0] low;
	// lower bound per gain code
	always_comb
	begin
		case (gain_code)
			2'b00: low = RF2_R_MIN_G0;
			2'b01: low = RF2_R_MIN_G1;
			2'b10: low = RF2_R_MIN_G2;
			default: low = RF2_R_MIN_G3;
		endcase
	end
	assign ok = (value >= low) && (value <= RF2_R_MAX);
endmodule

// ---- core/sdp_device.sv ----
module sdp_device
	import sdp_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	sdp_link_if.device link,
	input wire logic auto_power_down,
	output logic if_synth_on,
	output logic rf_synth_on,
	output logic [RF1_N_W-1:0] rf1_feedback_count,
	output logic [RF2_N_W-1:0] rf2_feedback_count,
	output logic [IF_N_W-1:0] if_feedback_count,
	output logic [REF_W-1:0] rf1_reference_count,
	output logic [REF_W-1:0] rf2_reference_count
);
	logic [1:0] power_control;

	// power word; reserved bits dropped
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			power_control <= '0;
		else if (link.wr_valid && link.wr_addr == ADDR_POWER)
			power_control <= {link.wr_data[BIT_IF_ON], link.wr_data[BIT_RF_ON]};
	end

	// divider words, unused upper bits discarded
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			rf1_feedback_count <= '0;
			rf2_feedback_count <= '0;
			if_feedback_count <= '0;
			rf1_reference_count <= '0;
			rf2_reference_count <= '0;
		end
		else if (link.wr_valid)
		begin
			if (link.wr_addr == ADDR_RF1_N)
				rf1_feedback_count <= link.wr_data[RF1_N_W-1:0];
			else if (link.wr_addr == ADDR_RF2_N)
				rf2_feedback_count <= link.wr_data[RF2_N_W-1:0];
			else if (link.wr_addr == ADDR_IF_N)
				if_feedback_count <= link.wr_data[IF_N_W-1:0];
			else if (link.wr_addr == ADDR_RF1_R)
				rf1_reference_count <= link.wr_data[REF_W-1:0];
			else if (link.wr_addr == ADDR_RF2_R)
				rf2_reference_count <= link.wr_data[REF_W-1:0];
		end
	end

	// auto power-down overrides stored bits, so no write is needed
	assign if_synth_on = power_control[BIT_IF_ON] | auto_power_down;
	assign rf_synth_on = power_control[BIT_RF_ON] | auto_power_down;
endmodule

// ---- core/sdp_host.sv ----
// host end: software stages a word then launches it; checks range limits
module sdp_host
	import sdp_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	sdp_link_if.host link,
	input wire logic [1:0] rf2_detector_gain_code,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata
);
	sdp_state_e state;
	logic [DATA_W-1:0] data;
	logic [ADDR_W-1:0] addr;
	logic sent_pulse;
	logic rejected;
	logic go;
	logic ok;
	logic rf2_ok;

	sdp_rf2_ref_check i_sdp_rf2_ref_check (
		.value(data[REF_W-1:0]),
		.gain_code(rf2_detector_gain_code),
		.ok(rf2_ok)
	);

	// legality of staged word; upper bits must be zero
	always_comb
	begin
		ok = 1'b1;
		if (addr >= ADDR_RSV_LO)
			ok = 1'b0;
		else if (addr == ADDR_POWER)
			ok = (data[DATA_W-1:BIT_IF_ON+1] == '0);
		else if (addr == ADDR_RF1_N)
			ok = (data >= RF1_N_MIN);
		else if (addr == ADDR_RF2_N)
			ok = !data[DATA_W-1] && data[RF2_N_W-1:0] >= RF2_N_MIN;
		else if (addr == ADDR_IF_N)
			ok = (data[DATA_W-1:IF_N_W] == '0) && data[IF_N_W-1:0] >= IF_N_MIN;
		else if (addr == ADDR_RF1_R)
			ok = (data[DATA_W-1:REF_W] == '0);
		else if (addr == ADDR_RF2_R)
			ok = (data[DATA_W-1:REF_W] == '0) && rf2_ok;
	end

	assign go = reg_write && reg_addr == HREG_CMD;

	// staged data and address; frozen while busy so the checked word is sent
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			data <= '0;
		else if (reg_write && reg_addr == HREG_DATA && state == SDP_IDLE)
			data <= reg_wdata[DATA_W-1:0];
	end

	// a launch while busy is ignored, address included
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			addr <= '0;
		else if (go && state == SDP_IDLE)
			addr <= reg_wdata[ADDR_W-1:0];
	end

	// one-cycle send, or a sticky reject when illegal
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			state <= SDP_IDLE;
			rejected <= 1'b0;
			sent_pulse <= 1'b0;
		end
		else
		begin
			sent_pulse <= 1'b0;
			case (state)
				SDP_IDLE:
				begin
					if (go)
						state <= SDP_SEND;
				end
				SDP_SEND:
				begin
					if (ok)
					begin
						sent_pulse <= 1'b1;
						rejected <= 1'b0;
					end
					else
						rejected <= 1'b1;
					state <= SDP_IDLE;
				end
				default: state <= SDP_IDLE;
			endcase
		end
	end

	assign link.wr_valid = sent_pulse;
	assign link.wr_data = data;
	assign link.wr_addr = addr;

	// read data one cycle after strobe
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			reg_rdata <= '0;
		else if (reg_read)
		begin
			if (reg_addr == HREG_DATA)
				reg_rdata <= {14'h0000, data};
			else if (reg_addr == HREG_CMD)
				reg_rdata <= {28'h000_0000, addr};
			else if (reg_addr == HREG_STATUS)
				reg_rdata <= {30'h0000_0000, rejected, state != SDP_IDLE};
			else
				reg_rdata <= '0;
		end
	end
endmodule

// ---- tb/sdp_chk.sv ----
module sdp_chk
	import sdp_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic wr_valid,
	input wire logic [3:0] wr_addr,
	input wire logic [17:0] wr_data,
	input wire logic auto_power_down,
	input wire logic if_synth_on,
	input wire logic rf_synth_on,
	input wire logic [17:0] rf1_feedback_count,
	input wire logic [16:0] rf2_feedback_count,
	input wire logic [15:0] if_feedback_count,
	input wire logic [12:0] rf1_reference_count,
	input wire logic [12:0] rf2_reference_count
);
	// one clock domain, so clocking and reset stated once
	default clocking @(posedge clock);
	endclocking
	default disable iff (sys_rst);
	// each word's used bits must land in its own output the edge after
	chk_if_power_bit: assert property (
		wr_valid && wr_addr == ADDR_POWER |=>
		if_synth_on == ($past(wr_data[1]) | auto_power_down))
		else $error("if power bit wrong");
	chk_rf_power_bit: assert property (
		wr_valid && wr_addr == ADDR_POWER |=>
		rf_synth_on == ($past(wr_data[0]) | auto_power_down))
		else $error("rf power bit wrong");
	chk_rf1_fb_load: assert property (
		wr_valid && wr_addr == ADDR_RF1_N |=>
		rf1_feedback_count == $past(wr_data)) else $error("rf1 n");
	chk_rf2_fb_load: assert property (
		wr_valid && wr_addr == ADDR_RF2_N |=>
		rf2_feedback_count == $past(wr_data[16:0])) else $error("rf2 n");
	chk_if_fb_load: assert property (
		wr_valid && wr_addr == ADDR_IF_N |=>
		if_feedback_count == $past(wr_data[15:0])) else $error("if n");
	chk_rf1_ref_load: assert property (
		wr_valid && wr_addr == ADDR_RF1_R |=>
		rf1_reference_count == $past(wr_data[12:0])) else $error("rf1 r");
	chk_rf2_ref_load: assert property (
		wr_valid && wr_addr == ADDR_RF2_R |=>
		rf2_reference_count == $past(wr_data[12:0])) else $error("rf2 r");
	// override is a level, it must win at once
	chk_auto_forces_on: assert property (
		auto_power_down |-> if_synth_on && rf_synth_on)
		else $error("auto power-down ignored");
	// host must never launch a reserved address or a power word with upper bits set
	chk_no_reserved_send: assert property (
		wr_valid |-> wr_addr < ADDR_RSV_LO)
		else $error("reserved address sent");
	chk_power_upper_zero: assert property (
		wr_valid && wr_addr == ADDR_POWER |-> wr_data[17:2] == '0)
		else $error("power word upper bits set");
	cover property (wr_valid && wr_addr == ADDR_POWER);
	cover property (wr_valid && wr_addr == ADDR_RF2_R);
	cover property (auto_power_down && if_synth_on);
endmodule

// ---- tb/synth_divider_power_regs_bench.sv ----
module synth_divider_power_regs_bench
	import sdp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 0;
	logic sys_rst = 1;
	logic auto_power_down = 0;
	logic reg_write = 0;
	logic reg_read = 0;
	logic [1:0] rf2_detector_gain_code = 0;
	logic [3:0] reg_addr = 0;
	logic [31:0] reg_wdata = 0;
	logic [31:0] reg_rdata;
	logic if_synth_on, rf_synth_on;
	logic [17:0] rf1_feedback_count;
	logic [16:0] rf2_feedback_count;
	logic [15:0] if_feedback_count;
	logic [12:0] rf1_reference_count, rf2_reference_count;
	logic [17:0] e [8] = '{default: 0};
	int miscompares = 0, num_checks = 0, cyc = 0;
	sdp_link_if i_sdp_link_if();
	sdp_device i_sdp_device(.clock, .sys_rst, .link(i_sdp_link_if),
		.auto_power_down, .if_synth_on, .rf_synth_on, .rf1_feedback_count,
		.rf2_feedback_count, .if_feedback_count, .rf1_reference_count,
		.rf2_reference_count);
	sdp_host i_sdp_host(.clock, .sys_rst, .link(i_sdp_link_if),
		.rf2_detector_gain_code, .reg_addr, .reg_wdata, .reg_write,
		.reg_read, .reg_rdata);
	sdp_chk i_sdp_chk(.clock, .sys_rst, .wr_valid(i_sdp_link_if.wr_valid),
		.wr_addr(i_sdp_link_if.wr_addr), .wr_data(i_sdp_link_if.wr_data),
		.auto_power_down, .if_synth_on, .rf_synth_on, .rf1_feedback_count,
		.rf2_feedback_count, .if_feedback_count, .rf1_reference_count,
		.rf2_reference_count);
	// clock and hang guard; 1000 cycles is far past the run
	initial forever #10 clock = ~clock;
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 1000)
		begin
			miscompares++;
			print_verdict();
		end
	end
	task print_verdict;
		if (miscompares == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input string n, input logic [78:0] x, input logic [78:0] g);
		num_checks++;
		if (g !== x)
		begin
			miscompares++;
			$display("MISMATCH %s exp %h got %h", n, x, g);
		end
	endtask
	// strobes drop a cycle later so no signal is set twice in a step
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= w;
		reg_read <= !w;
		@(posedge clock);
		reg_write <= 1'b0;
		reg_read <= 1'b0;
	endtask
	task out_chk;
		chk("outputs", {e[2][1] | auto_power_down, e[2][0] | auto_power_down,
			e[3], e[4][16:0], e[5][15:0], e[6][12:0], e[7][12:0]},
			{if_synth_on, rf_synth_on, rf1_feedback_count, rf2_feedback_count,
			if_feedback_count, rf1_reference_count, rf2_reference_count});
	endtask
	// a refused word must leave every output as it was
	task step(input logic [1:0] g, input logic [3:0] a, input logic [17:0] d,
		input logic rej);
		@(posedge clock);
		rf2_detector_gain_code <= g;
		bus(1'b1, HREG_DATA, {14'h0000, d});
		bus(1'b1, HREG_CMD, {28'h000_0000, a});
		repeat (4) @(posedge clock);
		if (!rej)
			e[a[2:0]] = d;
		#1 out_chk();
		bus(1'b0, HREG_STATUS, 32'h0000_0000);
		#1 chk("status", {77'h0, rej, 1'b0}, {77'h0, reg_rdata[1:0]});
	endtask
	initial
	begin
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		step(2'h0, 4'h3, 18'h0_03e0, 1'b0);
		step(2'h0, 4'h3, 18'h0_03df, 1'b1);
		step(2'h0, 4'h4, 18'h1_ffff, 1'b0);
		step(2'h0, 4'h4, 18'h2_00f0, 1'b1);
		step(2'h0, 4'h5, 18'h0_0038, 1'b0);
		step(2'h0, 4'h5, 18'h0_0037, 1'b1);
		step(2'h0, 4'h6, 18'h0_1fff, 1'b0);
		step(2'h0, 4'h7, 18'h0_1ffd, 1'b0);
		step(2'h0, 4'h7, 18'h0_1ffe, 1'b1);
		step(2'h3, 4'h7, 18'h0_000d, 1'b1);
		step(2'h3, 4'h7, 18'h0_000e, 1'b0);
		step(2'h0, 4'h2, 18'h0_0002, 1'b0);
		step(2'h0, 4'h2, 18'h0_0001, 1'b0);
		step(2'h0, 4'h9, 18'h0_0000, 1'b1);
		bus(1'b0, HREG_CMD, 32'h0000_0000);
		#1 chk("cmd", 79'h0009, {47'h0, reg_rdata});
		// mid-run reset must clear every stored word
		@(posedge clock);
		sys_rst <= 1'b1;
		@(posedge clock);
		sys_rst <= 1'b0;
		e = '{default: 0};
		#1 out_chk();
		@(posedge clock);
		auto_power_down <= 1'b1;
		@(posedge clock);
		#1 out_chk();
		print_verdict();
	end
endmodule
